// *** inc/dmac_pkg.sv ***
// Constants and types of the DMA channel control block
package dmac_pkg;

  // Register byte offsets on the AHB-Lite slave
  localparam logic [7:0]  OFF_CTRL   = 8'h00;
  localparam logic [7:0]  OFF_STAT   = 8'h04;
  localparam logic [7:0]  OFF_MASK   = 8'h08;
  localparam logic [7:0]  OFF_BUFA   = 8'h0c;
  localparam logic [7:0]  OFF_BUFB   = 8'h10;
  localparam logic [7:0]  OFF_PADR   = 8'h14;
  localparam logic [7:0]  OFF_BLEN   = 8'h18;
  localparam logic [7:0]  OFF_STATE  = 8'h1c;

  // Channel control field positions
  localparam int          CTL_ON     = 15;
  localparam int          CTL_BYTE   = 14;
  localparam int          CTL_DIR    = 13;
  localparam int          CTL_HALF   = 12;
  localparam int          CTL_DUMMY_PERIPH_WRITE  = 11;
  localparam int          ADDRESSING_SCHEME_LO   = 4;
  localparam int          OMODE_LO   = 0;
  localparam logic [15:0] CTRL_WMASK = 16'hf833;

  // Status field positions
  localparam int          STAT_W     = 2;
  localparam int          ST_BLK     = 0;
  localparam int          ST_ERR     = 1;

  // Reset values
  localparam logic [15:0]       CTRL_RST = 16'h0000;
  localparam logic [15:0]       REG_RST  = 16'h0000;
  localparam logic [STAT_W-1:0] STAT_RST = 2'h0;

  // Bus constants
  localparam logic [2:0]  HSIZE_WORD = 3'h2;

  typedef enum logic [1:0] {
    AM_POSTINC = 2'b00,
    AM_NOINC   = 2'b01,
    AM_PERIND  = 2'b10,
    AM_RSVD    = 2'b11
  } dmac_addressing_scheme_e;

  typedef enum logic [1:0] {
    OM_CONT       = 2'b00,
    OM_ONESHOT    = 2'b01,
    OM_CONT_PP    = 2'b10,
    OM_ONESHOT_PP = 2'b11
  } dmac_omode_e;

  typedef enum logic [1:0] {
    S_IDLE  = 2'b00,
    S_READ  = 2'b01,
    S_WRITE = 2'b10,
    S_NULL  = 2'b11
  } dmac_state_e;

  typedef struct packed {
    logic        valid;
    logic        we;
    logic        periph;
    logic        byte_sz;
    logic [15:0] addr;
    logic [15:0] wdata;
  } dmac_req_s;

  typedef struct packed {
    logic        ack;
    logic [15:0] rdata;
  } dmac_rsp_s;

endpackage

// *** rtl/dmac_addr_gen.sv ***
// RAM address generation for the DMA channel
`timescale 1ns/1ps
module dmac_addr_gen (
  // Clock and reset
  input  logic                  clk_sys,
  input  logic                  srst,
  // Sequencing
  input  logic                  load,
  input  logic                  step,
  input  logic                  sel_b,
  // Configuration
  input  dmac_pkg::dmac_addressing_scheme_e scheme,
  input  logic                  byte_sz,
  input  logic [15:0]           base_a,
  input  logic [15:0]           base_b,
  input  logic [15:0]           poff,
  // Result
  output logic [15:0]           ram_addr
);
  import dmac_pkg::*;

  logic [15:0] ofs_r;
  logic [15:0] base;
  logic [15:0] inc;

  assign base = sel_b ? base_b : base_a;
  assign inc  = byte_sz ? 16'h0001 : 16'h0002;

  // Offset advances only with post-increment
  always_ff @(posedge clk_sys) begin
    if (srst || load) begin
      ofs_r <= 16'h0000;
    end else if (step && scheme == AM_POSTINC) begin
      ofs_r <= ofs_r + inc;
    end
  end

  // Peripheral indirect takes the offset from the peripheral
  always_comb begin
    ram_addr = base + ((scheme == AM_PERIND) ? poff : ofs_r);
  end

  a_noinc_hold: assert property (
    @(posedge clk_sys) disable iff (srst)
    (step && !load && scheme != AM_POSTINC) |=> ofs_r == $past(ofs_r)
  ) else $error("offset moved without post-increment");

  a_postinc_step: assert property (
    @(posedge clk_sys) disable iff (srst)
    (step && !load && scheme == AM_POSTINC)
      |=> ofs_r == $past(ofs_r) + ($past(byte_sz) ? 16'h0001 : 16'h0002)
  ) else $error("post-increment step wrong");

endmodule

// *** rtl/dmac_blk_cnt.sv ***
// Element counter with half and full block detection
`timescale 1ns/1ps
module dmac_blk_cnt (
  // Clock and reset
  input  logic        clk_sys,
  input  logic        srst,
  // Sequencing
  input  logic        clr,
  input  logic        step,
  input  logic [16:0] n_elems,
  // Results
  output logic        half_hit,
  output logic        full_hit,
  output logic [16:0] done_cnt
);
  import dmac_pkg::*;

  logic [16:0] cnt_r;
  logic [16:0] cnt_inc;
  logic [16:0] half_pt;

  assign cnt_inc  = cnt_r + 17'd1;
  assign half_pt  = {1'b0, n_elems[16:1]} + {16'h0000, n_elems[0]};
  assign half_hit = step && (cnt_inc == half_pt);
  assign full_hit = step && (cnt_inc == n_elems);
  assign done_cnt = cnt_r;

  always_ff @(posedge clk_sys) begin
    if (srst || clr) begin
      cnt_r <= 17'd0;
    end else if (step) begin
      cnt_r <= cnt_inc;
    end
  end

endmodule

// *** rtl/dmac_chan.sv ***
// DMA channel control: AHB-Lite registers, sequencer and interrupt
//
// Contract
// - The size bit picks byte transfers at one and word transfers at zero.
// - Direction one reads RAM and writes the peripheral, zero the reverse.
// - With the half bit set the interrupt event fires at half the block.
// - Null-write adds a dummy peripheral write after each RAM write.
// - Scheme 10 is peripheral indirect, 01 no post-increment, 11 reserved.
// - Modes 11 one-shot ping-pong, 10 continuous ping-pong, 01 one-shot.
// - Control bits 10 to 6 and 3 to 2 always read as zero.
//
// Implementation choices: the address map and the AHB-Lite slave port.
`timescale 1ns/1ps
module dmac_chan (
  // Clock and reset
  input  logic                clk_sys,
  input  logic                srst,
  // AHB-Lite slave
  input  logic                hsel,
  input  logic [31:0]         haddr,
  input  logic [1:0]          htrans,
  input  logic                hwrite,
  input  logic [2:0]          hsize,
  input  logic [31:0]         hwdata,
  input  logic                hready,
  output logic                hreadyout,
  output logic                hresp,
  output logic [31:0]         hrdata,
  // Peripheral request
  input  logic                periph_req,
  input  logic [15:0]         periph_off,
  // Data mover port
  output dmac_pkg::dmac_req_s mem_req,
  input  dmac_pkg::dmac_rsp_s mem_rsp,
  // Interrupt
  output logic                irq
);
  import dmac_pkg::*;

  // Registers
  logic [15:0]       ctrl_r;
  logic [STAT_W-1:0] stat_r;
  logic [STAT_W-1:0] mask_r;
  logic [15:0]       bufa_r;
  logic [15:0]       bufb_r;
  logic [15:0]       padr_r;
  logic [15:0]       blen_r;
  logic              wr_pend_r;
  logic [7:0]        wr_off_r;
  logic [31:0]       hrdata_r;
  logic              hreadyout_r;
  logic              irq_r;

  // Sequencer state
  dmac_state_e       st_r;
  dmac_req_s         req_r;
  logic              el_dir_r;
  logic              el_byte_r;
  logic              el_dummy_periph_write_r;
  logic              req_pend_r;
  logic [15:0]       poff_r;
  logic              buf_b_r;

  // Decoded control
  logic              ctl_on;
  logic              ctl_byte;
  logic              ctl_dir;
  logic              ctl_half;
  logic              ctl_dummy_periph_write;
  dmac_addressing_scheme_e       ctl_scheme;
  dmac_omode_e       ctl_mode;
  logic              cfg_bad;

  // Events and strobes
  logic              rd_go;
  logic              wr_go;
  logic              sw_ctrl_wr;
  logic              sw_stat_wr;
  logic              w_bad;
  logic              start_blk;
  logic              el_go;
  logic              el_done;
  logic              half_hit;
  logic              blk_full;
  logic              blk_evt;
  logic              err_evt;
  logic              stop_hw;
  logic              pp_mode;
  logic              blk_clr;
  logic [16:0]       n_elems;
  logic [16:0]       done_cnt;
  logic [15:0]       ram_addr;
  logic [31:0]       rd_val;

  assign hreadyout = hreadyout_r;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_r;
  assign mem_req   = req_r;
  assign irq       = irq_r;

  assign ctl_on     = ctrl_r[CTL_ON];
  assign ctl_byte   = ctrl_r[CTL_BYTE];
  assign ctl_dir    = ctrl_r[CTL_DIR];
  assign ctl_half   = ctrl_r[CTL_HALF];
  assign ctl_dummy_periph_write  = ctrl_r[CTL_DUMMY_PERIPH_WRITE];
  assign ctl_scheme = dmac_addressing_scheme_e'(ctrl_r[ADDRESSING_SCHEME_LO +: 2]);
  assign ctl_mode   = dmac_omode_e'(ctrl_r[OMODE_LO +: 2]);
  // Reserved scheme or null-write with direction one blocks the channel
  assign cfg_bad    = (ctl_scheme == AM_RSVD) || (ctl_dummy_periph_write && ctl_dir);

  // Bus decode
  assign rd_go = hsel && hready && htrans[1] && !hwrite;
  assign wr_go = hsel && hready && htrans[1] && hwrite && (hsize == HSIZE_WORD);
  assign sw_ctrl_wr = wr_pend_r && (wr_off_r == OFF_CTRL);
  assign sw_stat_wr = wr_pend_r && (wr_off_r == OFF_STAT);
  assign w_bad = (hwdata[ADDRESSING_SCHEME_LO +: 2] == AM_RSVD)
               || (hwdata[CTL_DUMMY_PERIPH_WRITE] && hwdata[CTL_DIR]);
  assign start_blk = sw_ctrl_wr && hwdata[CTL_ON] && !ctl_on;
  assign err_evt   = sw_ctrl_wr && hwdata[CTL_ON] && w_bad;

  // Sequencing strobes
  assign el_go = (st_r == S_IDLE) && ctl_on && req_pend_r && !cfg_bad
               && !sw_ctrl_wr;
  assign el_done = mem_rsp.ack
                 && (((st_r == S_WRITE) && !el_dummy_periph_write_r) || (st_r == S_NULL));
  assign blk_evt = ctl_half ? half_hit : blk_full;
  assign pp_mode = (ctl_mode == OM_CONT_PP) || (ctl_mode == OM_ONESHOT_PP);
  assign stop_hw = blk_full && ((ctl_mode == OM_ONESHOT)
                 || ((ctl_mode == OM_ONESHOT_PP) && buf_b_r));
  assign blk_clr = start_blk || blk_full;
  assign n_elems = {1'b0, blen_r} + 17'd1;

  // Register read view
  always_comb begin
    rd_val = 32'h0000_0000;
    unique case (haddr[7:0])
      OFF_CTRL:  rd_val = {16'h0000, ctrl_r & CTRL_WMASK};
      OFF_STAT:  rd_val = {30'h0000_0000, stat_r};
      OFF_MASK:  rd_val = {30'h0000_0000, mask_r};
      OFF_BUFA:  rd_val = {16'h0000, bufa_r};
      OFF_BUFB:  rd_val = {16'h0000, bufb_r};
      OFF_PADR:  rd_val = {16'h0000, padr_r};
      OFF_BLEN:  rd_val = {16'h0000, blen_r};
      OFF_STATE: rd_val = {done_cnt[15:0], 12'h000, req_pend_r, buf_b_r, st_r};
      default:   rd_val = 32'h0000_0000;
    endcase
  end

  // AHB-Lite slave, zero wait states
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      hreadyout_r <= 1'b0;
      hrdata_r    <= 32'h0000_0000;
      wr_pend_r   <= 1'b0;
      wr_off_r    <= 8'h00;
    end else begin
      hreadyout_r <= 1'b1;
      wr_pend_r   <= wr_go;
      wr_off_r    <= haddr[7:0];
      if (rd_go) begin
        hrdata_r <= rd_val;
      end
    end
  end

  // Channel control; software write beats the one-shot stop
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      ctrl_r <= CTRL_RST;
    end else if (sw_ctrl_wr) begin
      ctrl_r <= hwdata[15:0] & CTRL_WMASK;
    end else if (stop_hw) begin
      ctrl_r[CTL_ON] <= 1'b0;
    end
  end

  // Plain configuration registers
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      mask_r <= STAT_RST;
      bufa_r <= REG_RST;
      bufb_r <= REG_RST;
      padr_r <= REG_RST;
      blen_r <= REG_RST;
    end else if (wr_pend_r) begin
      unique case (wr_off_r)
        OFF_MASK: mask_r <= hwdata[STAT_W-1:0];
        OFF_BUFA: bufa_r <= hwdata[15:0];
        OFF_BUFB: bufb_r <= hwdata[15:0];
        OFF_PADR: padr_r <= hwdata[15:0];
        OFF_BLEN: blen_r <= hwdata[15:0];
        default: ;
      endcase
    end
  end

  // Sticky status, write one to clear, set wins
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      stat_r <= STAT_RST;
    end else begin
      stat_r[ST_BLK] <= blk_evt
                     || (stat_r[ST_BLK] && !(sw_stat_wr && hwdata[ST_BLK]));
      stat_r[ST_ERR] <= err_evt
                     || (stat_r[ST_ERR] && !(sw_stat_wr && hwdata[ST_ERR]));
    end
  end

  // Interrupt level
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |(stat_r & mask_r);
    end
  end

  // Pending peripheral request, new request wins over consumption
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      req_pend_r <= 1'b0;
      poff_r     <= 16'h0000;
    end else begin
      req_pend_r <= periph_req || (req_pend_r && !el_go);
      if (periph_req) begin
        poff_r <= periph_off;
      end
    end
  end

  // Ping-pong buffer select
  always_ff @(posedge clk_sys) begin
    if (srst || start_blk) begin
      buf_b_r <= 1'b0;
    end else if (blk_full && pp_mode) begin
      buf_b_r <= !buf_b_r;
    end
  end

  // Element sequencer
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      st_r       <= S_IDLE;
      req_r      <= '0;
      el_dir_r   <= 1'b0;
      el_byte_r  <= 1'b0;
      el_dummy_periph_write_r <= 1'b0;
    end else begin
      unique case (st_r)
        S_IDLE: begin
          if (el_go) begin
            el_dir_r      <= ctl_dir;
            el_byte_r     <= ctl_byte;
            el_dummy_periph_write_r    <= ctl_dummy_periph_write;
            req_r.valid   <= 1'b1;
            req_r.we      <= 1'b0;
            req_r.periph  <= !ctl_dir;
            req_r.byte_sz <= ctl_byte;
            req_r.addr    <= ctl_dir ? ram_addr : padr_r;
            req_r.wdata   <= 16'h0000;
            st_r          <= S_READ;
          end
        end
        S_READ: begin
          if (mem_rsp.ack) begin
            req_r.we     <= 1'b1;
            req_r.periph <= el_dir_r;
            req_r.addr   <= el_dir_r ? padr_r : ram_addr;
            req_r.wdata  <= el_byte_r ? {8'h00, mem_rsp.rdata[7:0]}
                                      : mem_rsp.rdata;
            st_r         <= S_WRITE;
          end
        end
        S_WRITE: begin
          if (mem_rsp.ack) begin
            if (el_dummy_periph_write_r) begin
              req_r.periph <= 1'b1;
              req_r.addr   <= padr_r;
              req_r.wdata  <= 16'h0000;
              st_r         <= S_NULL;
            end else begin
              req_r.valid <= 1'b0;
              st_r        <= S_IDLE;
            end
          end
        end
        S_NULL: begin
          if (mem_rsp.ack) begin
            req_r.valid <= 1'b0;
            st_r        <= S_IDLE;
          end
        end
      endcase
    end
  end

  dmac_addr_gen u_addr_gen (
    .clk_sys  (clk_sys),
    .srst     (srst),
    .load     (blk_clr),
    .step     (el_done),
    .sel_b    (buf_b_r),
    .scheme   (ctl_scheme),
    .byte_sz  (el_byte_r),
    .base_a   (bufa_r),
    .base_b   (bufb_r),
    .poff     (poff_r),
    .ram_addr (ram_addr)
  );

  dmac_blk_cnt u_blk_cnt (
    .clk_sys  (clk_sys),
    .srst     (srst),
    .clr      (blk_clr),
    .step     (el_done),
    .n_elems  (n_elems),
    .half_hit (half_hit),
    .full_hit (blk_full),
    .done_cnt (done_cnt)
  );

  a_issue_needs_on: assert property (
    @(posedge clk_sys) disable iff (srst)
    (st_r == S_IDLE ##1 st_r == S_READ) |-> $past(ctrl_r[CTL_ON])
  ) else $error("element started while channel off");

  a_size_follows: assert property (
    @(posedge clk_sys) disable iff (srst)
    (st_r == S_IDLE ##1 st_r == S_READ)
      |-> req_r.byte_sz == $past(ctrl_r[CTL_BYTE])
  ) else $error("transfer size differs from control");

  a_byte_masked: assert property (
    @(posedge clk_sys) disable iff (srst)
    (st_r == S_WRITE && el_byte_r) |-> req_r.wdata[15:8] == 8'h00
  ) else $error("byte write carries upper data");

  a_read_bus: assert property (
    @(posedge clk_sys) disable iff (srst)
    (st_r == S_READ) |-> (req_r.periph == !el_dir_r) && !req_r.we
  ) else $error("read on wrong bus");

  a_write_bus: assert property (
    @(posedge clk_sys) disable iff (srst)
    (st_r == S_WRITE) |-> (req_r.periph == el_dir_r) && req_r.we
  ) else $error("write on wrong bus");

  a_half_irq: assert property (
    @(posedge clk_sys) disable iff (srst)
    (half_hit && ctrl_r[CTL_HALF]) |=> stat_r[ST_BLK]
  ) else $error("half block event missing");

  a_full_only: assert property (
    @(posedge clk_sys) disable iff (srst)
    $rose(stat_r[ST_BLK])
      |-> $past(ctrl_r[CTL_HALF] ? half_hit : blk_full)
  ) else $error("block event at wrong moment");

  a_dummy_write: assert property (
    @(posedge clk_sys) disable iff (srst)
    (st_r == S_WRITE && mem_rsp.ack && el_dummy_periph_write_r)
      |=> (st_r == S_NULL) && req_r.we && req_r.periph
          && (req_r.addr == padr_r)
  ) else $error("dummy peripheral write missing");

  a_oneshot_stop: assert property (
    @(posedge clk_sys) disable iff (srst)
    (blk_full && ctl_mode == OM_ONESHOT && !sw_ctrl_wr)
      |=> !ctrl_r[CTL_ON]
  ) else $error("one-shot did not stop");

  a_pp_flip: assert property (
    @(posedge clk_sys) disable iff (srst)
    (blk_full && ctl_mode == OM_CONT_PP && !start_blk)
      |=> buf_b_r != $past(buf_b_r)
  ) else $error("ping-pong buffer did not switch");

  a_cont_keeps: assert property (
    @(posedge clk_sys) disable iff (srst)
    (blk_full && ctl_on && ctl_mode == OM_CONT && !sw_ctrl_wr)
      |=> ctrl_r[CTL_ON] && (buf_b_r == $past(buf_b_r))
  ) else $error("continuous mode stopped or switched");

  a_rsvd_zero: assert property (
    @(posedge clk_sys) disable iff (srst)
    (rd_go && haddr[7:0] == OFF_CTRL)
      |=> (hrdata_r[15:0] & ~CTRL_WMASK) == 16'h0000
  ) else $error("reserved control bits read nonzero");

endmodule

// *** sim/dmac_mem_model.sv ***
// RAM and peripheral bus model answering the channel's data mover port
`timescale 1ns/1ps
module dmac_mem_model (
  // Clock and reset
  input  wire logic          clk_sys,
  input  wire logic          srst,
  // Answer speed
  input  wire logic          slow,
  // Data mover port
  input  dmac_pkg::dmac_req_s mem_req,
  output dmac_pkg::dmac_rsp_s mem_rsp
);
  import dmac_pkg::*;
  dmac_req_s  lg [64];
  int         n_log;
  logic [2:0] wait_r;

  // Ack after a wait, read data from address, garbage otherwise
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      mem_rsp <= '0;
      wait_r  <= 3'h0;
      n_log   <= 0;
    end else if (mem_rsp.ack) begin
      mem_rsp.ack   <= 1'b0;
      mem_rsp.rdata <= ~mem_rsp.rdata;
      wait_r        <= 3'h0;
    end else if (mem_req.valid) begin
      if (wait_r >= (slow ? 3'h3 : 3'h0)) begin
        mem_rsp.ack   <= 1'b1;
        mem_rsp.rdata <= mem_req.addr ^ 16'h5a5a;
        lg[n_log]     <= mem_req;
        n_log         <= n_log + 1;
      end else begin
        wait_r <= wait_r + 3'h1;
      end
    end else begin
      mem_rsp.rdata <= ~mem_rsp.rdata;
    end
  end
endmodule

// *** sim/testbench.sv ***
// Self-checking bench of the DMA channel control block
`timescale 1ns/1ps
module testbench;
  import dmac_pkg::*;
  logic        clk_sys = 1'b0;
  logic        srst    = 1'b1;
  logic        hsel    = 1'b0;
  logic [31:0] haddr   = 32'h0;
  logic [1:0]  htrans  = 2'h0;
  logic        hwrite  = 1'b0;
  logic [2:0]  hsize   = 3'h2;
  logic [31:0] hwdata  = 32'h0;
  logic        hreadyout;
  logic        hresp;
  logic [31:0] hrdata;
  logic        periph_req = 1'b0;
  logic [15:0] periph_off = 16'h0;
  logic        slow       = 1'b0;
  dmac_req_s   mem_req;
  dmac_rsp_s   mem_rsp;
  logic        irq;
  int          error_cnt  = 0;
  int          num_checks = 0;
  int          cyc        = 0;
  logic [31:0] d;
  localparam logic [15:0] PA = 16'h0040;

  always #2.5 clk_sys = ~clk_sys;

  dmac_chan dut (.clk_sys(clk_sys), .srst(srst), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .periph_req(periph_req),
    .periph_off(periph_off), .mem_req(mem_req), .mem_rsp(mem_rsp),
    .irq(irq));
  dmac_mem_model pm (.clk_sys(clk_sys), .srst(srst), .slow(slow),
    .mem_req(mem_req), .mem_rsp(mem_rsp));

  task report_and_stop;
    if (error_cnt == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      error_cnt++;
      report_and_stop;
    end
  end

  task chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task wr(input logic [7:0] a, input logic [31:0] v);
    hsel <= 1'b1; haddr <= {24'h0, a}; htrans <= 2'b10;
    hwrite <= 1'b1; hsize <= HSIZE_WORD;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    hsel <= 1'b0; htrans <= 2'b00; hwdata <= v;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
  endtask

  task rd(input logic [7:0] a, input logic [31:0] exp);
    hsel <= 1'b1; haddr <= {24'h0, a}; htrans <= 2'b10; hwrite <= 1'b0;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    hsel <= 1'b0; htrans <= 2'b00;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    chk(hrdata, exp);
    chk(hresp, 1'b0);
  endtask

  task chk_req(input int k, input logic we, input logic per,
               input logic byt, input logic [15:0] a, input logic [15:0] wd);
    dmac_req_s g;
    g = pm.lg[k];
    if (!we) g.wdata = 16'h0;
    chk({28'h0, g.valid, g.we, g.periph, g.byte_sz},
        {28'h0, 1'b1, we, per, byt});
    chk({g.addr, g.wdata}, {a, wd});
  endtask

  // One element: request, wait for all bus steps, compare each step
  task xfer(input logic dir, input logic byt, input logic nul,
            input logic [15:0] ra, input logic [15:0] off);
    int k;
    logic [15:0] rv;
    logic [15:0] wv;
    k = pm.n_log;
    periph_req <= 1'b1; periph_off <= off;
    @(posedge clk_sys);
    periph_req <= 1'b0;
    for (int i = 0; i < 200 && pm.n_log < k + 2 + nul; i++)
      @(posedge clk_sys);
    rv = (dir ? ra : PA) ^ 16'h5a5a;
    wv = byt ? {8'h00, rv[7:0]} : rv;
    chk(pm.n_log, k + 2 + nul);
    chk_req(k, 1'b0, !dir, byt, dir ? ra : PA, 16'h0);
    chk_req(k + 1, 1'b1, dir, byt, dir ? PA : ra, wv);
    if (nul) chk_req(k + 2, 1'b1, 1'b1, byt, PA, 16'h0);
    repeat (4) @(posedge clk_sys);
  endtask

  task restart(input logic [15:0] c);
    wr(OFF_CTRL, 32'h0);
    wr(OFF_STAT, 32'h3);
    wr(OFF_CTRL, {16'h0, c});
  endtask

  initial begin
    repeat (10) @(posedge clk_sys);
    srst <= 1'b0;
    for (int i = 0; i < 20 && hreadyout !== 1'b1; i++) @(posedge clk_sys);
    rd(OFF_CTRL, 32'h0);
    rd(OFF_STAT, 32'h0);
    chk(irq, 1'b0);
    rd(8'h40, 32'h0);
    wr(OFF_CTRL, 32'h07cc);
    rd(OFF_CTRL, 32'h0);
    wr(OFF_BUFA, 32'h0100);
    wr(OFF_BUFB, 32'h0200);
    wr(OFF_PADR, {16'h0, PA});
    rd(OFF_PADR, {16'h0, PA});
    wr(OFF_BLEN, 32'h1);
    wr(OFF_MASK, 32'h1);
    // Continuous, word, post-increment, full-block event
    restart(16'h8000);
    rd(OFF_CTRL, 32'h8000);
    xfer(1'b0, 1'b0, 1'b0, 16'h0100, 16'h0);
    rd(OFF_STAT, 32'h0);
    slow <= 1'b1;
    xfer(1'b0, 1'b0, 1'b0, 16'h0102, 16'h0);
    rd(OFF_STAT, 32'h1);
    chk(irq, 1'b1);
    wr(OFF_STAT, 32'h1);
    repeat (2) @(posedge clk_sys);
    chk(irq, 1'b0);
    xfer(1'b0, 1'b0, 1'b0, 16'h0100, 16'h0);
    rd(OFF_CTRL, 32'h8000);
    // Half-block event, masked then unmasked
    wr(OFF_MASK, 32'h0);
    restart(16'h9000);
    xfer(1'b0, 1'b0, 1'b0, 16'h0100, 16'h0);
    rd(OFF_STAT, 32'h1);
    chk(irq, 1'b0);
    wr(OFF_MASK, 32'h1);
    repeat (2) @(posedge clk_sys);
    chk(irq, 1'b1);
    // Byte, RAM to peripheral, with increment; word, peripheral to RAM, without
    restart(16'he000);
    xfer(1'b1, 1'b1, 1'b0, 16'h0100, 16'h0);
    xfer(1'b1, 1'b1, 1'b0, 16'h0101, 16'h0);
    restart(16'h8010);
    slow <= 1'b0;
    xfer(1'b0, 1'b0, 1'b0, 16'h0100, 16'h0);
    xfer(1'b0, 1'b0, 1'b0, 16'h0100, 16'h0);
    // Peripheral indirect with dummy writes, direction kept at zero
    restart(16'h8820);
    xfer(1'b0, 1'b0, 1'b1, 16'h0106, 16'h0006);
    // Operating modes
    for (int m = 1; m < 4; m++) begin
      restart(16'h8000 | 16'(m));
      xfer(1'b0, 1'b0, 1'b0, 16'h0100, 16'h0);
      xfer(1'b0, 1'b0, 1'b0, 16'h0102, 16'h0);
      if (m > 1) begin
        xfer(1'b0, 1'b0, 1'b0, 16'h0200, 16'h0);
        xfer(1'b0, 1'b0, 1'b0, 16'h0202, 16'h0);
      end
      rd(OFF_CTRL, (m == 2) ? 32'h8002 : 32'(m));
    end
    // Refused configurations leave the bus quiet
    for (int c = 0; c < 2; c++) begin
      d = pm.n_log;
      restart(c == 0 ? 16'h8830 : 16'ha800);
      periph_req <= 1'b1;
      @(posedge clk_sys);
      periph_req <= 1'b0;
      repeat (20) @(posedge clk_sys);
      chk(pm.n_log, d);
      rd(OFF_STAT, 32'h2);
    end
    // Disabled channel moves nothing
    restart(16'h0000);
    periph_req <= 1'b1;
    @(posedge clk_sys);
    periph_req <= 1'b0;
    repeat (20) @(posedge clk_sys);
    chk(pm.n_log, d);
    chk(mem_req.valid, 1'b0);
    rd(OFF_STATE, 32'h8);
    report_and_stop;
  end
endmodule
